// File: cuf_card_model.sv
// Behavioural smart card that clocks bytes toward the receive side
`timescale 1ns/1ns
module cuf_card_model (
   output logic card_clk_out,
   output logic card_io_out
);
   // ======================================================================
   // Idle line
   // The clock parks low between frames and the line sits at its pull-up level
   initial begin
      card_clk_out = 1'b0;
      card_io_out  = 1'b1;
   end

   // ======================================================================
   // Frame
   // Eight data bits LSB first, then the parity or ninth bit; the odd start
   // delay keeps the link clock out of phase with the system clock
   task automatic send(input logic [7:0] data, input logic bit9);
      logic [8:0] frame;
      frame = {bit9, data};
      #37;
      for (int i = 0; i < 9; i++) begin
         card_io_out = frame[i];
         #400 card_clk_out = 1'b1;
         #400 card_clk_out = 1'b0;
      end
      card_io_out = 1'b1;
   endtask
endmodule

// File: cuf_mem.sv
// Small byte memory with registered read data, used by both FIFOs
`timescale 1ns/1ns
module cuf_mem #(
   parameter int WIDTH = 8,
   parameter int AW    = 3
) (
   input  wire logic             ref_clk_in,
   input  wire logic             wr_en_in,
   input  wire logic [AW-1:0]    wr_addr_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic [AW-1:0]    rd_addr_in,
   output logic      [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem_q [2**AW];

   // ======================================================================
   // Storage is never cleared, only overwritten by writes
   always_ff @(posedge ref_clk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
      // Write-first, so an entry written this cycle reads back on the next one
      if (wr_en_in && wr_addr_in == rd_addr_in) begin
         rd_data_out <= wr_data_in;
      end else begin
         rd_data_out <= mem_q[rd_addr_in];
      end
   end
endmodule

// File: cuf_pkg.sv
// Package of constants for the card UART FIFO and receive status block
// ==========================================================================
// Overview of operation
// - Each write to the transmit data port pushes a byte into the transmit FIFO.
// - A read of the transmit data port advances the transmit read pointer unless the FIFO is empty.
// - Consuming transmit entries never clears storage; later writes overwrite.
// - Sync nine-bit mode: status bit 7 holds I/O level at ninth clock rise.
// - Last byte flagged by firmware; block mode checks CRC 1D0F or LRC 00.
// - Status bit 4 is a read-only check error flag for failed block checks.
// - Status bit 3 reads one while the receive FIFO is full.
// - Status bit 2 shows receive FIFO empty and never raises an interrupt.
// - Byte arriving while full sets overrun bit 1 and interrupt; read clears.
// - While overrun stands, further received bytes are discarded.
// - Parity error sets bit 0 and interrupt; status read clears it.
// - Receive data port is read-only and returns bytes in arrival order.
// - Ports sit at 0xfe07, 0xfe08, 0xfe09; after reset status reads 0x04 (empty set), mask at 0xfe0c reads 0x03.
// - Direction bit one drains transmit FIFO, zero fills receive FIFO.
// ==========================================================================
package cuf_pkg;
   // ======================================================================
   // Register addresses and reset values
   localparam logic [15:0] ADDR_TX_DATA   = 16'hfe07;
   localparam logic [15:0] ADDR_RX_STATUS = 16'hfe08;
   localparam logic [15:0] ADDR_RX_DATA   = 16'hfe09;
   localparam logic [15:0] ADDR_IRQ_MASK  = 16'hfe0c;
   localparam logic [7:0]  RESET_BYTE     = 8'h00;
   localparam logic [7:0]  MASK_RESET     = 8'h03;
   // ======================================================================
   // Status field positions
   localparam int BIT_NINTH   = 7;
   localparam int BIT_FINAL   = 5;
   localparam int BIT_CHECK   = 4;
   localparam int BIT_FULL    = 3;
   localparam int BIT_EMPTY   = 2;
   localparam int BIT_OVERRUN = 1;
   localparam int BIT_PARITY  = 0;
   // ======================================================================
   // Check residues, CRC polynomial and initial value, serial timing
   localparam logic [15:0] CRC_RESIDUE  = 16'h1d0f;
   localparam logic [7:0]  LRC_RESIDUE  = 8'h00;
   localparam logic [15:0] CRC_POLY     = 16'h1021;
   localparam logic [15:0] CRC_INIT     = 16'hffff;
   localparam logic [3:0]  NINTH_EDGE   = 4'h9;
   localparam logic [3:0]  BYTE_BITS    = 4'h8;
endpackage

// File: cuf_top.sv
// Card UART transmit/receive FIFOs, receive status and bit serial link
`timescale 1ns/1ns
module cuf_top #(
   parameter int TX_AW = 3,
   parameter int RX_AW = 3
) (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rdata_out,
   input  wire logic        direction_select_in,
   input  wire logic        sync_mode_in,
   input  wire logic        nine_bit_select_in,
   input  wire logic        block_mode_in,
   input  wire logic        lrc_select_in,
   input  wire logic        ext_select_in,
   input  wire logic        card_clk_in,
   input  wire logic        card_io_in,
   input  wire logic        ext_card_io_in,
   output logic             card_io_out,
   output logic             card_io_oe_out,
   output logic             rx_error_irq_out
);
   // ======================================================================
   // Elaboration check
   initial begin
      if (TX_AW < 1 || TX_AW > 8 || RX_AW < 1 || RX_AW > 8) begin
         $error("FIFO address width must be 1 to 8");
      end
   end

   // ======================================================================
   // State
   typedef struct packed {
      logic [TX_AW:0] tx_wp;
      logic [TX_AW:0] tx_rp;
      logic [RX_AW:0] rx_wp;
      logic [RX_AW:0] rx_rp;
      logic           final_rx_byte;
      logic           check_code_fault;
      logic           rx_overrun_flag;
      logic           parity_fault_flag;
      logic           ninth_bit_sample;
      logic [7:0]     irq_mask;
      logic [7:0]     rdata;
      logic           dir_prev;
      logic [3:0]     bit_cnt;
      logic [8:0]     shift;
      logic           clk_prev;
      logic           tx_busy;
      logic           io_out;
      logic           io_oe;
      logic           irq;
      logic [15:0]    crc;
      logic [7:0]     lrc;
   } cuf_state_t;

   cuf_state_t s_q;
   cuf_state_t s_d;

   // Two flip-flop synchronisers for the card pins
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic       clk_s;
   logic       io_s;
   logic       eio_s;

   always_ff @(posedge ref_clk_in) begin
      sync1_q <= {card_clk_in, card_io_in, ext_card_io_in};
      sync2_q <= sync1_q;
   end
   assign clk_s = sync2_q[2];
   assign io_s  = sync2_q[1];
   assign eio_s = sync2_q[0];

   // ======================================================================
   // Decodes and FIFO flags
   logic       sel_io;
   logic       clk_rise;
   logic       tx_empty;
   logic       rx_full;
   logic       rx_empty;
   logic       wr_tx;
   logic       rd_tx;
   logic       rd_stat;
   logic       rd_rx;
   logic       rx_push;
   logic       tx_pop;
   logic [7:0] tx_rd_data;
   logic [7:0] rx_rd_data;
   logic [7:0] status;
   logic [8:0] rx_byte;
   logic       byte_done;

   assign sel_io   = ext_select_in ? eio_s : io_s;
   assign clk_rise = clk_s & ~s_q.clk_prev;
   // Pointers carry one extra bit so full and empty differ
   assign tx_empty = (s_q.tx_wp == s_q.tx_rp);
   assign rx_empty = (s_q.rx_wp == s_q.rx_rp);
   assign rx_full  = (s_q.rx_wp[RX_AW] != s_q.rx_rp[RX_AW]) &&
                     (s_q.rx_wp[RX_AW-1:0] == s_q.rx_rp[RX_AW-1:0]);
   assign wr_tx    = wr_in && addr_in == cuf_pkg::ADDR_TX_DATA;
   assign rd_tx    = rd_in && addr_in == cuf_pkg::ADDR_TX_DATA;
   assign rd_stat  = rd_in && addr_in == cuf_pkg::ADDR_RX_STATUS;
   assign rd_rx    = rd_in && addr_in == cuf_pkg::ADDR_RX_DATA;
   assign rx_byte  = {sel_io, s_q.shift[8:1]};
   assign byte_done = clk_rise && !direction_select_in && s_q.bit_cnt == cuf_pkg::BYTE_BITS;
   assign rx_push  = byte_done && !rx_full && !s_q.rx_overrun_flag;
   // Serializer pops a byte when idle in transmit direction
   assign tx_pop   = direction_select_in && !s_q.tx_busy && !tx_empty && !rd_tx;

   always_comb begin
      status = 8'h00;
      status[cuf_pkg::BIT_NINTH]   = s_q.ninth_bit_sample;
      status[cuf_pkg::BIT_FINAL]   = s_q.final_rx_byte;
      status[cuf_pkg::BIT_CHECK]   = s_q.check_code_fault;
      status[cuf_pkg::BIT_FULL]    = rx_full;
      status[cuf_pkg::BIT_EMPTY]   = rx_empty;
      status[cuf_pkg::BIT_OVERRUN] = s_q.rx_overrun_flag;
      status[cuf_pkg::BIT_PARITY]  = s_q.parity_fault_flag;
   end

   // ======================================================================
   // Memories: reads follow the next read pointer so back-to-back reads see fresh data
   cuf_mem #(.WIDTH(8), .AW(TX_AW)) u_tx_mem (
      .ref_clk_in  (ref_clk_in),
      .wr_en_in    (wr_tx),
      .wr_addr_in  (s_q.tx_wp[TX_AW-1:0]),
      .wr_data_in  (wdata_in),
      .rd_addr_in  (s_d.tx_rp[TX_AW-1:0]),
      .rd_data_out (tx_rd_data)
   );

   cuf_mem #(.WIDTH(8), .AW(RX_AW)) u_rx_mem (
      .ref_clk_in  (ref_clk_in),
      .wr_en_in    (rx_push),
      .wr_addr_in  (s_q.rx_wp[RX_AW-1:0]),
      .wr_data_in  (rx_byte[7:0]),
      .rd_addr_in  (s_d.rx_rp[RX_AW-1:0]),
      .rd_data_out (rx_rd_data)
   );

   // ======================================================================
   // Next state
   always_comb begin
      logic       par;
      logic [7:0] b;
      logic [15:0] c;
      par = 1'b0;
      b   = 8'h00;
      c   = 16'h0000;
      s_d = s_q;
      s_d.clk_prev = clk_s;

      // Read data for the registers held in this block
      s_d.rdata = 8'h00;
      if (rd_stat) begin
         s_d.rdata = status;
      end else if (rd_in && addr_in == cuf_pkg::ADDR_IRQ_MASK) begin
         s_d.rdata = s_q.irq_mask;
      end

      // Transmit FIFO pointers
      if (wr_tx) begin
         s_d.tx_wp = s_q.tx_wp + 1'b1;
      end
      if (rd_tx && !tx_empty) begin
         s_d.tx_rp = s_q.tx_rp + 1'b1;
      end
      if (tx_pop) begin
         s_d.tx_rp = s_q.tx_rp + 1'b1;
      end

      // Firmware writes to the status register hold only the final byte bit
      if (wr_in && addr_in == cuf_pkg::ADDR_RX_STATUS) begin
         s_d.final_rx_byte = wdata_in[cuf_pkg::BIT_FINAL];
      end
      if (wr_in && addr_in == cuf_pkg::ADDR_IRQ_MASK) begin
         s_d.irq_mask = wdata_in;
      end

      // Receive pop, returns next byte in arrival order
      if (rd_rx && !rx_empty) begin
         s_d.rx_rp = s_q.rx_rp + 1'b1;
      end

      // Status read clears sticky errors; a same-cycle set wins below
      if (rd_stat) begin
         s_d.rx_overrun_flag   = 1'b0;
         s_d.parity_fault_flag = 1'b0;
         s_d.check_code_fault  = 1'b0;
      end

      // Link bit engine, clocked by sampled card clock edges
      if (clk_rise) begin
         if (direction_select_in) begin
            s_d.io_oe = s_q.tx_busy;
            s_d.io_out = s_q.shift[0];
            s_d.shift = {1'b1, s_q.shift[8:1]};
            if (s_q.tx_busy) begin
               s_d.bit_cnt = s_q.bit_cnt + 1'b1;
               if (s_q.bit_cnt == cuf_pkg::BYTE_BITS) begin
                  s_d.tx_busy = 1'b0;
                  s_d.bit_cnt = 4'h0;
               end
            end
         end else begin
            s_d.io_oe = 1'b0;
            s_d.shift = {sel_io, s_q.shift[8:1]};
            s_d.bit_cnt = s_q.bit_cnt + 1'b1;
            if (sync_mode_in && nine_bit_select_in &&
                s_q.bit_cnt == cuf_pkg::NINTH_EDGE - 4'h1) begin
               s_d.ninth_bit_sample = sel_io;
            end
            if (s_q.bit_cnt == cuf_pkg::BYTE_BITS) begin
               s_d.bit_cnt = 4'h0;
               b = rx_byte[7:0];
               par = ^rx_byte;
               if (!sync_mode_in && par) begin
                  s_d.parity_fault_flag = 1'b1;
               end
               if (rx_full || s_q.rx_overrun_flag) begin
                  s_d.rx_overrun_flag = 1'b1;
               end else begin
                  s_d.rx_wp = s_q.rx_wp + 1'b1;
               end
               // Running block check
               c = s_q.crc;
               for (int i = 7; i >= 0; i--) begin
                  c = (c[15] ^ b[7-i]) ? {c[14:0], 1'b0} ^ cuf_pkg::CRC_POLY
                                       : {c[14:0], 1'b0};
               end
               s_d.crc = c;
               s_d.lrc = s_q.lrc ^ b;
               if (block_mode_in && s_q.final_rx_byte) begin
                  if (lrc_select_in ? ((s_q.lrc ^ b) != cuf_pkg::LRC_RESIDUE)
                                    : (c != cuf_pkg::CRC_RESIDUE)) begin
                     s_d.check_code_fault = 1'b1;
                  end
                  s_d.crc = cuf_pkg::CRC_INIT;
                  s_d.lrc = cuf_pkg::LRC_RESIDUE;
               end
            end
         end
      end

      // Load the serializer with the popped entry; its data stand in this cycle
      // because the memory is read at the next read pointer
      if (tx_pop) begin
         s_d.tx_busy = 1'b1;
         s_d.bit_cnt = 4'h0;
         s_d.shift   = {1'b1, tx_rd_data};
      end

      // Switching direction restarts the check logic and the bit count, so a
      // new block never inherits the residue of an earlier one
      s_d.dir_prev = direction_select_in;
      if (direction_select_in != s_q.dir_prev) begin
         s_d.crc     = cuf_pkg::CRC_INIT;
         s_d.lrc     = cuf_pkg::LRC_RESIDUE;
         s_d.bit_cnt = 4'h0;
         s_d.io_oe   = 1'b0;
      end

      // Empty flag never feeds the interrupt
      s_d.irq = |({6'h00, s_d.rx_overrun_flag, s_d.parity_fault_flag} &
                  s_q.irq_mask);
   end

   // ======================================================================
   // Register the state
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s_q <= '0;
         s_q.shift <= 9'h1ff;
         s_q.crc <= cuf_pkg::CRC_INIT;
         s_q.irq_mask <= cuf_pkg::MASK_RESET;
         s_q.io_out <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ======================================================================
   // Outputs; receive data uses the memory's registered read port
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rdata_out        <= 8'h00;
         card_io_out      <= 1'b1;
         card_io_oe_out   <= 1'b0;
         rx_error_irq_out <= 1'b0;
      end else begin
         card_io_out      <= s_d.io_out;
         card_io_oe_out   <= s_d.io_oe;
         rx_error_irq_out <= s_d.irq;
         rdata_out        <= s_d.rdata;
         if (rd_rx) begin
            rdata_out <= rx_rd_data;
         end else if (rd_tx) begin
            rdata_out <= tx_rd_data;
         end
      end
   end

   // ======================================================================
   // Assertions
   property p_tx_read_advances;
      @(posedge ref_clk_in) disable iff (rst_in)
      (rd_tx && !tx_empty && !wr_tx) |=> (s_q.tx_rp == $past(s_q.tx_rp) + 1'b1);
   endproperty
   a_tx_read_advances: assert property (p_tx_read_advances)
      else $error("transmit read did not advance pointer");

   property p_tx_write_pushes;
      @(posedge ref_clk_in) disable iff (rst_in)
      wr_tx |=> (s_q.tx_wp == $past(s_q.tx_wp) + 1'b1);
   endproperty
   a_tx_write_pushes: assert property (p_tx_write_pushes)
      else $error("transmit write did not push");

   property p_overrun_sets;
      @(posedge ref_clk_in) disable iff (rst_in)
      (byte_done && rx_full) |=> s_q.rx_overrun_flag;
   endproperty
   a_overrun_sets: assert property (p_overrun_sets)
      else $error("overrun flag not set");

   property p_overrun_discards;
      @(posedge ref_clk_in) disable iff (rst_in)
      (byte_done && s_q.rx_overrun_flag) |=> (s_q.rx_wp == $past(s_q.rx_wp));
   endproperty
   a_overrun_discards: assert property (p_overrun_discards)
      else $error("byte stored during overrun");

   property p_full_flag;
      @(posedge ref_clk_in) disable iff (rst_in)
      rd_stat |=> (rdata_out[cuf_pkg::BIT_FULL] == $past(rx_full));
   endproperty
   a_full_flag: assert property (p_full_flag)
      else $error("full flag wrong");

   property p_empty_no_irq;
      @(posedge ref_clk_in) disable iff (rst_in)
      (!s_q.rx_overrun_flag && !s_q.parity_fault_flag) |-> !rx_error_irq_out;
   endproperty
   a_empty_no_irq: assert property (p_empty_no_irq)
      else $error("interrupt without error");

   property p_read_clears;
      @(posedge ref_clk_in) disable iff (rst_in)
      (rd_stat && !clk_rise) |=> (!s_q.parity_fault_flag && !s_q.rx_overrun_flag);
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("status read did not clear");

   property p_rx_order;
      @(posedge ref_clk_in) disable iff (rst_in)
      (rd_rx && !rx_empty) |=> (s_q.rx_rp == $past(s_q.rx_rp) + 1'b1);
   endproperty
   a_rx_order: assert property (p_rx_order)
      else $error("receive pointer did not advance");
endmodule

// File: test_cuf_top.sv
// Self-checking testbench for the card UART FIFO and receive status block
`timescale 1ns/1ns
module test_cuf_top;
   localparam logic [15:0] ADDR_UNMAPPED = 16'hfe0d;
   logic        ref_clk_in          = 1'b0;
   logic        rst_in              = 1'b1;
   logic [15:0] addr_in             = 16'h0000;
   logic [7:0]  wdata_in            = 8'h00;
   logic        wr_in               = 1'b0;
   logic        rd_in               = 1'b0;
   logic        direction_select_in = 1'b0;
   logic        sync_mode_in        = 1'b0;
   logic        nine_bit_select_in  = 1'b0;
   logic        block_mode_in       = 1'b0;
   logic        lrc_select_in       = 1'b0;
   logic        ext_select_in       = 1'b0;
   logic [7:0]  rdata_out;
   logic        card_io_out;
   logic        card_io_oe_out;
   logic        rx_error_irq_out;
   logic        card_clk;
   logic        model_io;
   logic        io_line;
   logic        card_io_in;
   logic        ext_card_io_in;
   int          fail_count = 0;
   int          num_checks = 0;

   // ======================================================================
   // Clock, open-drain line and instances
   always #50 ref_clk_in = ~ref_clk_in;
   // Either party may pull the line low; the unused pin rests at its pull-up
   assign io_line        = model_io & (card_io_oe_out ? card_io_out : 1'b1);
   assign card_io_in     = ext_select_in ? 1'b1 : io_line;
   assign ext_card_io_in = ext_select_in ? io_line : 1'b1;

   cuf_card_model i_cuf_card_model (.card_clk_out(card_clk), .card_io_out(model_io));

   cuf_top #(.TX_AW(3), .RX_AW(3)) i_cuf_top (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .direction_select_in(direction_select_in), .sync_mode_in(sync_mode_in),
      .nine_bit_select_in(nine_bit_select_in), .block_mode_in(block_mode_in),
      .lrc_select_in(lrc_select_in), .ext_select_in(ext_select_in),
      .card_clk_in(card_clk), .card_io_in(card_io_in), .ext_card_io_in(ext_card_io_in),
      .card_io_out(card_io_out), .card_io_oe_out(card_io_oe_out),
      .rx_error_irq_out(rx_error_irq_out));

   // ======================================================================
   // Bus and check tasks
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge ref_clk_in);
      wr_in    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the taken edge
   task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] m,
                         input logic [7:0] exp);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge ref_clk_in);
      rd_in   <= 1'b0;
      @(negedge ref_clk_in);
      check(name, rdata_out & m, exp);
   endtask

   // Two reads with no idle cycle between the strobes
   task automatic rd2_chk(input string name, input logic [15:0] a, input logic [7:0] e0,
                          input logic [7:0] e1);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      check(name, rdata_out, e0);
      @(posedge ref_clk_in);
      rd_in   <= 1'b0;
      @(negedge ref_clk_in);
      check(name, rdata_out, e1);
   endtask

   // Leaves time for the pin synchronisers and the push to land
   task automatic rx(input logic [7:0] d, input logic b9);
      @(posedge ref_clk_in);
      i_cuf_card_model.send(d, b9);
      repeat (8) @(posedge ref_clk_in);
   endtask

   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      check("irq", {7'h00, rx_error_irq_out}, {7'h00, exp});
   endtask

   // Flipping the direction restarts the block check logic
   task automatic reinit;
      @(posedge ref_clk_in);
      direction_select_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      direction_select_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
   endtask

   task automatic end_sim;
      if (fail_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ======================================================================
   // Watchdog: the sequence needs well under a third of this span
   initial begin
      #3000000;
      fail_count++;
      end_sim();
   end

   // ======================================================================
   // Main sequence
   initial begin
      logic [7:0] d;
      repeat (5) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rd_chk("status", cuf_pkg::ADDR_RX_STATUS, 8'hff, 8'h04);
      check("io oe", {7'h00, card_io_oe_out}, 8'h00);
      check("io out", {7'h00, card_io_out}, 8'h01);
      irq_chk(1'b0);
      rd_chk("unmapped", ADDR_UNMAPPED, 8'hff, 8'h00);
      // Transmit port: reads consume, writes refill
      wr(cuf_pkg::ADDR_TX_DATA, 8'ha1);
      wr(cuf_pkg::ADDR_TX_DATA, 8'hb2);
      rd_chk("tx data", cuf_pkg::ADDR_TX_DATA, 8'hff, 8'ha1);
      rd_chk("tx data", cuf_pkg::ADDR_TX_DATA, 8'hff, 8'hb2);
      wr(cuf_pkg::ADDR_TX_DATA, 8'hc3);
      rd_chk("tx data", cuf_pkg::ADDR_TX_DATA, 8'hff, 8'hc3);
      // Fill the receive FIFO, then push two bytes past full
      for (int k = 0; k < 10; k++) begin
         d = 8'h30 + 8'(k);
         rx(d, ^d);
         if (k == 7) rd_chk("full", cuf_pkg::ADDR_RX_STATUS, 8'hff, 8'h08);
         if (k == 7) irq_chk(1'b0);
         if (k == 8) irq_chk(1'b1);
      end
      rd_chk("overrun", cuf_pkg::ADDR_RX_STATUS, 8'hff, 8'h0a);
      rd_chk("overrun", cuf_pkg::ADDR_RX_STATUS, 8'hff, 8'h08);
      irq_chk(1'b0);
      for (int k = 0; k < 8; k += 2) begin
         rd2_chk("rx data", cuf_pkg::ADDR_RX_DATA, 8'h30 + 8'(k), 8'h31 + 8'(k));
      end
      rd_chk("empty", cuf_pkg::ADDR_RX_STATUS, 8'hff, 8'h04);
      // Block check with longitudinal redundancy: good block, then bad block
      block_mode_in <= 1'b1;
      lrc_select_in <= 1'b1;
      reinit();
      rx(8'h5a, 1'b0);
      wr(cuf_pkg::ADDR_RX_STATUS, 8'h20);
      rx(8'h5a, 1'b0);
      rd_chk("check", cuf_pkg::ADDR_RX_STATUS, 8'h10, 8'h00);
      wr(cuf_pkg::ADDR_RX_STATUS, 8'h00);
      reinit();
      rx(8'h5a, 1'b0);
      wr(cuf_pkg::ADDR_RX_STATUS, 8'h20);
      rx(8'h5b, 1'b1);
      rd_chk("check", cuf_pkg::ADDR_RX_STATUS, 8'h10, 8'h10);
      wr(cuf_pkg::ADDR_RX_STATUS, 8'h00);
      // Synchronous nine-bit frames on the external pin
      @(posedge ref_clk_in);
      block_mode_in      <= 1'b0;
      sync_mode_in       <= 1'b1;
      nine_bit_select_in <= 1'b1;
      ext_select_in      <= 1'b1;
      rx(8'h81, 1'b1);
      rd_chk("ninth", cuf_pkg::ADDR_RX_STATUS, 8'h80, 8'h80);
      rx(8'h81, 1'b0);
      rd_chk("ninth", cuf_pkg::ADDR_RX_STATUS, 8'h80, 8'h00);
      @(posedge ref_clk_in);
      sync_mode_in       <= 1'b0;
      nine_bit_select_in <= 1'b0;
      ext_select_in      <= 1'b0;
      // Parity fault while masked, then unmasked, then cleared by a read
      wr(cuf_pkg::ADDR_IRQ_MASK, 8'h00);
      rx(8'h11, ~^8'h11);
      irq_chk(1'b0);
      wr(cuf_pkg::ADDR_IRQ_MASK, 8'h03);
      irq_chk(1'b1);
      rd_chk("parity", cuf_pkg::ADDR_RX_STATUS, 8'h01, 8'h01);
      irq_chk(1'b0);
      rd_chk("parity", cuf_pkg::ADDR_RX_STATUS, 8'h01, 8'h00);
      end_sim();
   end
endmodule
